// ===== core/blcm_meter.sv
// Buck load-current meter: select/result registers and measurement control
`timescale 1ns/1ps

// Operation
// - Select register write starts a new measurement
// - Select bit zero picks regulator, resets zero
// - High register bit zero holds result bit eight
// - Low register holds result bits seven..zero
// - One result count equals 20 mA
module blcm_meter #(
    parameter int unsigned LOG2_SAMPLES = blcm_pkg::LOG2_SAMPLES_DEF
) (
    // Clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    arst_n_i,
    // Register access
    input  wire blcm_pkg::blcm_reg_req_s reg_req_i,
    output logic                         rvalid_o,
    output logic [7:0]                   rdata_o,
    // Current sense converter
    input  wire blcm_pkg::blcm_sample_s  sample_i,
    output logic                         sense_sel_o,
    // Status
    output logic                         meas_busy_o,
    output logic                         meas_done_o
);

    // Deepest averaging window the accumulator is sized for
    localparam int unsigned MAX_LOG2_SAMPLES = 16;

    // Register width, and result bits held by the low register
    localparam int unsigned REG_W = 8;
    localparam int unsigned LOW_W = blcm_pkg::RESULT_MSB;

    if (LOG2_SAMPLES > MAX_LOG2_SAMPLES) begin : g_bad_log2
        $error("blcm_meter: LOG2_SAMPLES too large");
    end

    // The result must split into one top bit and one full low register
    if (LOW_W != REG_W ||
        blcm_pkg::RESULT_W != LOW_W + 1) begin : g_bad_split
        $error("blcm_meter: result does not fit the two registers");
    end

    typedef enum logic {
        BLCM_IDLE,
        BLCM_MEASURE
    } blcm_state_e;

    // Measurement control
    blcm_state_e                   state_q;
    blcm_state_e                   state_d;
    logic                          start;
    logic                          measuring;
    // Select register
    logic [REG_W-1:0]              select_q;
    logic [REG_W-1:0]              select_d;
    blcm_pkg::blcm_reg_sel_e       regulator;
    // Result register
    logic [blcm_pkg::RESULT_W-1:0] result_q;
    logic [blcm_pkg::RESULT_W-1:0] result_d;
    logic                          avg_done;
    logic [blcm_pkg::RESULT_W-1:0] avg_val;
    // Read port
    logic                          rvalid_q;
    logic                          rvalid_d;
    logic [REG_W-1:0]              rdata_q;
    logic [REG_W-1:0]              rdata_d;

    // Address match, shared by the write and read decoders
    function automatic logic hit(
        input logic [REG_W-1:0] a,
        input logic [REG_W-1:0] o
    );
        return a == o;
    endfunction : hit

    // High register: top result bit in bit zero, the rest read as zero
    function automatic logic [REG_W-1:0] high_word(
        input logic [blcm_pkg::RESULT_W-1:0] res
    );
        logic [REG_W-1:0] w;
        w = blcm_pkg::HIGH_RST;
        w[blcm_pkg::HIGH_BIT] = res[blcm_pkg::RESULT_MSB];
        return w;
    endfunction : high_word

    // Low register: the result bits below the top one
    function automatic logic [REG_W-1:0] low_word(
        input logic [blcm_pkg::RESULT_W-1:0] res
    );
        return res[LOW_W-1:0];
    endfunction : low_word

    // Read data for one offset; unmapped offsets read as zero
    function automatic logic [REG_W-1:0] read_word(
        input logic [REG_W-1:0]              addr,
        input logic [REG_W-1:0]              sel,
        input logic [blcm_pkg::RESULT_W-1:0] res
    );
        logic [REG_W-1:0] w;
        w = blcm_pkg::RDATA_RST;
        if (hit(addr, blcm_pkg::SELECT_OFFS)) begin
            w = sel;
        end else if (hit(addr, blcm_pkg::RESULT_HIGH_OFFS)) begin
            w = high_word(res);
        end else if (hit(addr, blcm_pkg::RESULT_LOW_OFFS)) begin
            w = low_word(res);
        end
        return w;
    endfunction : read_word

    // Any write to the select offset starts a measurement, whatever data
    assign start = reg_req_i.wr &&
                   hit(reg_req_i.addr, blcm_pkg::SELECT_OFFS);
    assign measuring = (state_q == BLCM_MEASURE);

    blcm_avg #(
        .SAMPLE_W     (blcm_pkg::RESULT_W),
        .LOG2_SAMPLES (LOG2_SAMPLES)
    ) u_avg (
        .core_clk_i     (core_clk_i),
        .arst_n_i       (arst_n_i),
        .clear_i        (start),
        .active_i       (measuring),
        .sample_valid_i (sample_i.valid),
        .sample_i       (sample_i.code),
        .done_o         (avg_done),
        .avg_o          (avg_val)
    );

    // Measurement control: a write mid-measurement restarts the count
    always_comb begin
        state_d = state_q;
        if (start) begin
            state_d = BLCM_MEASURE;
        end else begin
            unique case (state_q)
                BLCM_IDLE: begin
                    state_d = BLCM_IDLE;
                end
                BLCM_MEASURE: begin
                    if (avg_done) begin
                        state_d = BLCM_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= BLCM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Select register: all bits stored, bit zero picks the regulator
    always_comb begin
        select_d = select_q;
        if (start) begin
            select_d = reg_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            select_q <= blcm_pkg::SELECT_RST;
        end else begin
            select_q <= select_d;
        end
    end

    // Result register: loaded only when a measurement completes, so
    // both halves always come from the same average
    always_comb begin
        result_d = result_q;
        if (!start && measuring && avg_done) begin
            // Converter code is already 20 mA per count
            result_d = avg_val;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    // Register read path: a read in a write cycle sees the old value
    always_comb begin
        rvalid_d = reg_req_i.rd;
        rdata_d  = rdata_q;
        if (reg_req_i.rd) begin
            rdata_d = read_word(reg_req_i.addr, select_q, result_q);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= blcm_pkg::RDATA_RST;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
        end
    end

    assign regulator   =
        blcm_pkg::blcm_reg_sel_e'(select_q[blcm_pkg::SEL_BIT]);
    assign rvalid_o    = rvalid_q;
    assign rdata_o     = rdata_q;
    assign sense_sel_o =
        (regulator == blcm_pkg::BLCM_SECOND_REGULATOR);
    assign meas_busy_o = measuring;
    assign meas_done_o = (state_q == BLCM_IDLE);

endmodule : blcm_meter

// ===== core/blcm_pkg.sv
// Package of constants and types for the buck load-current meter
package blcm_pkg;

    // Register offsets
    localparam logic [7:0] SELECT_OFFS      = 8'h24;
    localparam logic [7:0] RESULT_HIGH_OFFS = 8'h25;
    localparam logic [7:0] RESULT_LOW_OFFS  = 8'h26;

    // Field layout
    localparam int unsigned SEL_BIT      = 0;
    localparam int unsigned RESULT_W     = 9;
    localparam int unsigned RESULT_MSB   = 8;
    localparam int unsigned HIGH_BIT     = 0;

    // Reset values
    localparam logic [7:0] SELECT_RST = 8'h00;
    localparam logic [7:0] HIGH_RST   = 8'h00;
    localparam logic [7:0] LOW_RST    = 8'h00;
    localparam logic [7:0] RDATA_RST  = 8'h00;

    // Scale: one count of the result in milliamperes
    localparam int unsigned MA_PER_COUNT = 20;

    // Default number of samples per measurement, as a power of two
    localparam int unsigned LOG2_SAMPLES_DEF = 4;

    typedef enum logic {
        BLCM_FIRST_REGULATOR  = 1'b0,
        BLCM_SECOND_REGULATOR = 1'b1
    } blcm_reg_sel_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } blcm_reg_req_s;

    typedef struct packed {
        logic                valid;
        logic [RESULT_W-1:0] code;
    } blcm_sample_s;

endpackage : blcm_pkg

// ===== core/blcm_avg.sv
// Averaging accumulator for load-current samples
`timescale 1ns/1ps

module blcm_avg #(
    parameter int unsigned SAMPLE_W     = 9,
    parameter int unsigned LOG2_SAMPLES = 4
) (
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                arst_n_i,
    // Control
    input  wire logic                clear_i,
    input  wire logic                active_i,
    // Samples
    input  wire logic                sample_valid_i,
    input  wire logic [SAMPLE_W-1:0] sample_i,
    // Result
    output logic                     done_o,
    output logic      [SAMPLE_W-1:0] avg_o
);

    localparam int unsigned ACC_W = SAMPLE_W + LOG2_SAMPLES;
    localparam int unsigned CNT_W = LOG2_SAMPLES + 1;
    localparam logic [CNT_W-1:0] LAST_CNT =
        CNT_W'((1 << LOG2_SAMPLES) - 1);

    // Deepest averaging window the counters are sized for
    localparam int unsigned MAX_LOG2_SAMPLES = 16;

    if (SAMPLE_W < 1 || LOG2_SAMPLES > MAX_LOG2_SAMPLES) begin : g_bad_param
        $error("blcm_avg: unsupported parameter values");
    end

    logic [ACC_W-1:0]    acc_q, acc_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic                done_q, done_d;
    logic [SAMPLE_W-1:0] avg_q, avg_d;
    logic [ACC_W-1:0]    sum;

    always_comb begin
        sum    = acc_q + ACC_W'(sample_i);
        acc_d  = acc_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        avg_d  = avg_q;
        if (clear_i) begin
            acc_d = '0;
            cnt_d = '0;
        end else if (active_i && sample_valid_i) begin
            acc_d = sum;
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == LAST_CNT) begin
                done_d = 1'b1;
                avg_d  = sum[ACC_W-1:LOG2_SAMPLES];
                acc_d  = '0;
                cnt_d  = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_q  <= '0;
            cnt_q  <= '0;
            done_q <= 1'b0;
            avg_q  <= '0;
        end else begin
            acc_q  <= acc_d;
            cnt_q  <= cnt_d;
            done_q <= done_d;
            avg_q  <= avg_d;
        end
    end

    assign done_o = done_q;
    assign avg_o  = avg_q;

endmodule : blcm_avg

// ===== verification/blcm_meter_monitor.sv
// Port checker for the load-current meter
`timescale 1ns/1ps
module blcm_meter_monitor (
    // Clock and reset
    input wire logic                    core_clk_i,
    input wire logic                    arst_n_i,
    // Register access
    input wire blcm_pkg::blcm_reg_req_s reg_req_i,
    input wire logic                    rvalid_o,
    input wire logic [7:0]              rdata_o,
    // Sense and status
    input wire blcm_pkg::blcm_sample_s  sample_i,
    input wire logic                    sense_sel_o,
    input wire logic                    meas_busy_o,
    input wire logic                    meas_done_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    wire logic sel_wr = reg_req_i.wr &&
                        reg_req_i.addr == blcm_pkg::SELECT_OFFS;
    wire logic rd25   = reg_req_i.rd &&
                        reg_req_i.addr == blcm_pkg::RESULT_HIGH_OFFS;
    wire logic wd0    = reg_req_i.wdata[blcm_pkg::SEL_BIT];
    chk_rd_answer: assert property (reg_req_i.rd |=> rvalid_o)
        else $error("read not answered");
    chk_no_answer: assert property (!reg_req_i.rd |=> !rvalid_o)
        else $error("answer without read");
    chk_sel_load: assert property (
        sel_wr |=> sense_sel_o == $past(wd0))
        else $error("select not loaded");
    chk_sel_hold: assert property (
        !sel_wr |=> $stable(sense_sel_o))
        else $error("select changed");
    chk_meas_start: assert property (sel_wr |=> meas_busy_o)
        else $error("measurement not started");
    chk_done_flag: assert property (meas_done_o != meas_busy_o)
        else $error("done and busy agree");
    chk_high_zero: assert property (
        rd25 |=> rdata_o[7:1] == 7'h00)
        else $error("high register upper bits set");
    chk_rdata_hold: assert property (
        !reg_req_i.rd |=> $stable(rdata_o))
        else $error("read data changed");
    cover property (rd25);
    cover property ($fell(meas_busy_o));
    cover property (sel_wr && meas_busy_o);
endmodule : blcm_meter_monitor

bind blcm_meter blcm_meter_monitor u_mon (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i),
    .rvalid_o(rvalid_o), .rdata_o(rdata_o), .sample_i(sample_i),
    .sense_sel_o(sense_sel_o), .meas_busy_o(meas_busy_o),
    .meas_done_o(meas_done_o));

// ===== verification/test_blcm_meter.sv
// Self-checking testbench for the load-current meter
`timescale 1ns/1ps
module test_blcm_meter;
    localparam int unsigned LOG2 = 2;
    localparam int unsigned NS = 1 << LOG2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    blcm_pkg::blcm_reg_req_s req = '0;
    blcm_pkg::blcm_sample_s smp = '0;
    logic rvalid, sel, busy, done;
    logic [7:0] rd;
    logic [8:0] res = '0;
    logic [8:0] codes [NS];
    logic [7:0] adr [4] = '{8'h24, 8'h25, 8'h26, 8'h30};
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    blcm_meter #(.LOG2_SAMPLES(LOG2)) dut (.core_clk_i(clk),
        .arst_n_i(rst_n), .reg_req_i(req), .rvalid_o(rvalid),
        .rdata_o(rd), .sample_i(smp), .sense_sel_o(sel),
        .meas_busy_o(busy), .meas_done_o(done));

    initial forever #5 clk = ~clk;

    function automatic logic [8:0] avg();
        int s = 0;
        for (int i = 0; i < NS; i++) s += codes[i];
        return 9'(s >> LOG2);
    endfunction : avg

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick();
    endtask : wr_reg

    task automatic rd_reg(logic [7:0] a);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick();
        check("rvalid", rvalid, 1'b1);
    endtask : rd_reg

    task automatic read_res();
        rd_reg(8'h25);
        check("high", rd, {7'h00, res[8]});
        rd_reg(8'h26);
        check("low", rd, res[7:0]);
        req = '0;
        tick();
    endtask : read_res

    task automatic measure(logic [7:0] s, int n);
        wr_reg(8'h24, s);
        req = '0;
        check("busy", busy, 1'b1);
        check("sel", sel, s[0]);
        for (int i = 0; i < n; i++) begin
            smp = '{valid: 1'b1, code: codes[i]};
            tick();
        end
        smp = '0;
        if (n < NS) begin
            read_res();
            return;
        end
        res = avg();
        for (int i = 0; i < 8 && busy === 1'b1; i++) tick();
        check("done", done, 1'b1);
        read_res();
    endtask : measure

    task automatic conclude();
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        void'($urandom(52141));
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        check("reset_done", done, 1'b1);
        foreach (adr[i]) begin
            rd_reg(adr[i]);
            check("reset_val", rd, 8'h00);
        end
        wr_reg(8'h25, 8'hff);
        wr_reg(8'h26, 8'hff);
        rd_reg(8'h25);
        check("ro_high", rd, 8'h00);
        rd_reg(8'h26);
        check("ro_low", rd, 8'h00);
        wr_reg(8'h24, 8'ha5);
        rd_reg(8'h24);
        check("sel_rb", rd, 8'ha5);
        foreach (codes[i]) codes[i] = 9'h1ff;
        measure(8'h00, NS);
        check("full_ma", 16'(res * blcm_pkg::MA_PER_COUNT), 16'h27ec);
        for (int t = 0; t < 6; t++) begin
            foreach (codes[i]) codes[i] = 9'($urandom);
            measure(8'($urandom), (t == 2) ? 1 : NS);
        end
        // Reset in mid-measurement clears select, result and busy
        wr_reg(8'h24, 8'h01);
        req = '0;
        rst_n = 1'b0;
        tick();
        rst_n = 1'b1;
        check("rst_busy", busy, 1'b0);
        check("rst_sel", sel, 1'b0);
        res = '0;
        read_res();
        foreach (codes[i]) codes[i] = 9'h000;
        measure(8'h01, NS);
        conclude();
    end
endmodule : test_blcm_meter
